// ---- hw/sfp_pkg.sv ----
// Shared constants and types for the serial flash power and timing model
package sfp_pkg;
    localparam int LINK_NS = 160;
    localparam int REF_MHZ = 50;
    // Times in their printed units
    localparam int T_VCSL_US = 70;
    localparam int T_WRITE_STARTUP_MS = 3;
    localparam int T_EDPD_US = 3;
    localparam int T_RDPD_US = 8;
    localparam int T_ULTRA_EXIT_US = 70;
    localparam int T_OTPP_US = 950;
    localparam int T_WRSR_NS = 200;
    localparam int T_PP_US = 2500;
    localparam int T_BLKE_MS = 1000;
    localparam int T_CHPE_S = 4;
    localparam int T_CSLU_NS = 20;
    // Device counts on the link clock: longest times round down, except ultra-deep exit, which rounds up
    localparam int DEV_EDPD_CYC = (T_EDPD_US * 1000) / LINK_NS;
    localparam int DEV_RDPD_CYC = (T_RDPD_US * 1000) / LINK_NS;
    localparam int DEV_WRSR_CYC = (T_WRSR_NS / LINK_NS) < 1 ? 1 : T_WRSR_NS / LINK_NS;
    localparam int DEV_OTPP_CYC = (T_OTPP_US * 1000) / LINK_NS;
    localparam int DEV_PP_CYC = (T_PP_US * 1000) / LINK_NS;
    localparam longint DEV_BLKE_CYC = (64'(T_BLKE_MS) * 1000000) / LINK_NS;
    localparam longint DEV_CHPE_CYC = (64'(T_CHPE_S) * 1000000000) / LINK_NS;
    localparam int DEV_PUW_CYC = (T_WRITE_STARTUP_MS * 1000000) / LINK_NS;
    localparam int DEV_XUDPD_CYC = (T_ULTRA_EXIT_US * 1000 + LINK_NS - 1) / LINK_NS;
    // Host counts on ref_clk: least times round up
    localparam int REF_NS = 1000 / REF_MHZ;
    localparam int HOST_VCSL_CYC = (T_VCSL_US * 1000 + REF_NS - 1) / REF_NS;
    localparam int HOST_PUW_CYC = (T_WRITE_STARTUP_MS * 1000000 + REF_NS - 1) / REF_NS;
    localparam int HOST_XUDPD_CYC = (T_ULTRA_EXIT_US * 1000 + REF_NS - 1) / REF_NS;
    localparam int HOST_CSLU_CYC = (T_CSLU_NS + REF_NS - 1) / REF_NS;
    // Slow enough that the device's link clock resynchronises each half bit
    localparam int HOST_DIV = 64;
    // Opcodes
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_DUAL = 8'h3B;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_OTP_PROG = 8'h9B;
    localparam logic [7:0] OP_DEEP_PD = 8'hB9;
    localparam logic [7:0] OP_RESUME = 8'hAB;
    localparam logic [7:0] OP_ULTRA_PD = 8'h79;
    localparam logic [7:0] OP_RESET = 8'hF0;
    localparam logic [7:0] RESET_CONFIRM = 8'hD0;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam int BUSY_BIT = 0;
    typedef enum {PS_POR, PS_STARTUP, PS_STANDBY, PS_ACTIVE, PS_BUSY, PS_ENTER_DPD, PS_DPD,
        PS_RESUME, PS_ENTER_UDPD, PS_UDPD, PS_EXIT_UDPD} sfp_pstate_t;
endpackage

// ---- hw/sfp_link_if.sv ----
// SPI link between flash device and host
`timescale 1ns/1ns
`default_nettype none
interface sfp_link_if;
    logic chipSelectN;
    logic serialClk;
    logic mosi;
    logic miso;
    logic misoOe;
    modport dev(input chipSelectN, input serialClk, input mosi, output miso, output misoOe);
    modport host(output chipSelectN, output serialClk, output mosi, input miso, input misoOe);
endinterface
`default_nettype wire

// ---- hw/sfp_flash_dev.sv ----
// Flash device end: power states, opcode decode, operation timers
`timescale 1ns/1ns
`default_nettype none
module sfp_flash_dev
    import sfp_pkg::*;
#(
    parameter int PUW_CYC = DEV_PUW_CYC,
    parameter int PP_CYC = DEV_PP_CYC,
    parameter longint BLKE_CYC = DEV_BLKE_CYC,
    parameter longint CHPE_CYC = DEV_CHPE_CYC,
    parameter int OTPP_CYC = DEV_OTPP_CYC,
    parameter int XUDPD_CYC = DEV_XUDPD_CYC
) (
    input wire logic linkClk,
    input wire logic porRst,
    sfp_link_if.dev link,
    output logic [3:0] powerState,
    output logic clkMode3,
    output logic busy,
    output logic [7:0] lastOpcode
);
    sfp_pstate_t state;
    logic [2:0] csSync;
    logic csSeen;
    logic csFall;
    logic csRise;
    logic [2:0] bitCnt;
    logic [7:0] shiftIn;
    logic [1:0] byteCnt;
    logic [7:0] opcode;
    logic [7:0] confirm;
    logic [31:0] timer;
    logic [7:0] statusShift;
    logic [2:0] sclkSync;
    logic [2:0] mosiSync;
    logic sclkSeen;
    logic sclkRise;

    // All three link inputs pass three flops; equal delays keep data aligned to clock
    always_ff @(posedge linkClk) begin
        if (porRst) begin
            csSync <= 3'h7;
            csSeen <= 1'b1;
            sclkSync <= 3'h0;
            mosiSync <= 3'h0;
            sclkSeen <= 1'b0;
        end else begin
            csSync <= {csSync[1:0], link.chipSelectN};
            sclkSync <= {sclkSync[1:0], link.serialClk};
            mosiSync <= {mosiSync[1:0], link.mosi};
            if (csSync[2] == csSync[1])
                csSeen <= csSync[2];
            if (sclkSync[2] == sclkSync[1])
                sclkSeen <= sclkSync[2];
        end
    end
    assign csFall = csSeen && (csSync[2] == csSync[1]) && !csSync[2];
    assign csRise = !csSeen && (csSync[2] == csSync[1]) && csSync[2];
    assign sclkRise = !sclkSeen && sclkSync[2] && sclkSync[1];

    // Idle clock level at chip-select fall picks the mode
    always_ff @(posedge linkClk) begin
        if (porRst)
            clkMode3 <= 1'b0;
        else if (csFall)
            clkMode3 <= sclkSeen;
    end

    // Byte assembly while chip select is low
    always_ff @(posedge linkClk) begin
        if (porRst || csSeen) begin
            bitCnt <= 3'h0;
            byteCnt <= 2'h0;
            shiftIn <= 8'h00;
        end else if (sclkRise) begin
            shiftIn <= {shiftIn[6:0], mosiSync[2]};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7 && byteCnt != 2'h3)
                byteCnt <= byteCnt + 2'h1;
        end
    end

    always_ff @(posedge linkClk) begin
        if (porRst) begin
            opcode <= 8'h00;
            confirm <= 8'h00;
        end else if (csFall) begin
            opcode <= 8'h00;
            confirm <= 8'h00;
        end else if (!csSeen && sclkRise && bitCnt == 3'h7) begin
            if (byteCnt == 2'h0)
                opcode <= {shiftIn[6:0], mosiSync[2]};
            else if (byteCnt == 2'h1)
                confirm <= {shiftIn[6:0], mosiSync[2]};
        end
    end

    // Status byte out; tristated except during a status read
    always_ff @(posedge linkClk) begin
        if (porRst) begin
            statusShift <= 8'h00;
        end else if (sclkRise && bitCnt == 3'h7 && byteCnt == 2'h0) begin
            statusShift <= 8'(busy) << BUSY_BIT;
        end else if (sclkRise) begin
            statusShift <= {statusShift[6:0], 1'b0};
        end
    end
    always_ff @(posedge linkClk) begin
        if (porRst) begin
            link.misoOe <= 1'b0;
            link.miso <= 1'b0;
        end else begin
            link.misoOe <= !csSeen && byteCnt != 2'h0 && opcode == OP_READ_STATUS && state != PS_POR;
            link.miso <= statusShift[7];
        end
    end

    function automatic logic accepts(input sfp_pstate_t s);
        return s == PS_STANDBY || s == PS_ACTIVE;
    endfunction

    // Power state machine; porRst models the internal power-on reset
    always_ff @(posedge linkClk) begin
        if (porRst) begin
            state <= PS_POR;
            timer <= 32'h0;
            lastOpcode <= 8'h00;
        end else begin
            if (timer != 32'h0)
                timer <= timer - 32'h1;
            case (state)
                PS_POR: begin
                    state <= PS_STARTUP;
                    timer <= 32'(PUW_CYC);
                end
                PS_STARTUP: begin
                    if (timer == 32'h0)
                        state <= csSeen ? PS_STANDBY : PS_ACTIVE;
                end
                PS_STANDBY, PS_ACTIVE: begin
                    state <= csSeen ? PS_STANDBY : PS_ACTIVE;
                    if (csRise && accepts(state) && bitCnt == 3'h0) begin
                        lastOpcode <= opcode;
                        case (opcode)
                            OP_PAGE_PROG: begin state <= PS_BUSY; timer <= 32'(PP_CYC); end
                            OP_BLK64_ERASE: begin state <= PS_BUSY; timer <= 32'(BLKE_CYC); end
                            OP_CHIP_ERASE: begin state <= PS_BUSY; timer <= 32'(CHPE_CYC); end
                            OP_OTP_PROG: begin state <= PS_BUSY; timer <= 32'(OTPP_CYC); end
                            OP_WRITE_STATUS: begin state <= PS_BUSY; timer <= 32'(DEV_WRSR_CYC); end
                            OP_DEEP_PD: begin state <= PS_ENTER_DPD; timer <= 32'(DEV_EDPD_CYC); end
                            OP_ULTRA_PD: begin state <= PS_ENTER_UDPD; timer <= 32'(DEV_EDPD_CYC); end
                            OP_RESET: begin
                                if (byteCnt == 2'h2 && confirm == RESET_CONFIRM)
                                    state <= PS_STANDBY;
                            end
                            default: ;
                        endcase
                    end
                end
                PS_BUSY, PS_ENTER_DPD, PS_ENTER_UDPD, PS_RESUME, PS_EXIT_UDPD: begin
                    if (timer == 32'h0 || timer == 32'h1) begin
                        case (state)
                            PS_ENTER_DPD: state <= PS_DPD;
                            PS_ENTER_UDPD: state <= PS_UDPD;
                            default: state <= PS_STANDBY;
                        endcase
                    end
                end
                PS_DPD: begin
                    if (csRise && opcode == OP_RESUME) begin
                        state <= PS_RESUME;
                        timer <= 32'(DEV_RDPD_CYC);
                    end
                end
                PS_UDPD: begin
                    if (csFall) begin
                        state <= PS_EXIT_UDPD;
                        timer <= 32'(XUDPD_CYC);
                    end
                end
                default: state <= PS_POR;
            endcase
        end
    end

    assign powerState = 4'(state);
    assign busy = state == PS_BUSY;
endmodule
`default_nettype wire

// ---- hw/sfp_flash_host.sv ----
// Host end: issues one command, respecting startup and frequency limits
`timescale 1ns/1ns
`default_nettype none
module sfp_flash_host
    import sfp_pkg::*;
#(
    parameter int VCSL_CYC = HOST_VCSL_CYC,
    parameter int PUW_CYC = HOST_PUW_CYC,
    parameter int XUDPD_CYC = HOST_XUDPD_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    sfp_link_if.host link,
    input wire logic cmdValid,
    input wire logic [7:0] cmdOpcode,
    output logic cmdReady,
    output logic cmdDone
);
    typedef enum {HS_WAIT, HS_IDLE, HS_SEL, HS_SHIFT, HS_DESEL, HS_HOLD} sfp_hstate_t;
    sfp_hstate_t hs;
    logic [31:0] sinceUp;
    logic [31:0] hold;
    logic [15:0] shiftOut;
    logic [4:0] bitsLeft;
    logic [7:0] divCnt;
    logic sclk;

    // Startup wait: reads after 70 us, writes after 3 ms
    always_ff @(posedge ref_clk) begin
        if (srst)
            sinceUp <= 32'h0;
        else if (sinceUp != 32'hFFFF_FFFF)
            sinceUp <= sinceUp + 32'h1;
    end

    function automatic logic isWrite(input logic [7:0] op);
        return op == OP_PAGE_PROG || op == OP_BLK64_ERASE || op == OP_CHIP_ERASE ||
            op == OP_OTP_PROG || op == OP_WRITE_STATUS;
    endfunction

    // Clock divider: 50 MHz / (2*HOST_DIV) stays under every opcode ceiling
    always_ff @(posedge ref_clk) begin
        if (srst || hs != HS_SHIFT) begin
            divCnt <= 8'h0;
            sclk <= 1'b0;
        end else if (divCnt == 8'(HOST_DIV - 1)) begin
            divCnt <= 8'h0;
            sclk <= !sclk;
        end else begin
            divCnt <= divCnt + 8'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hs <= HS_WAIT;
            hold <= 32'h0;
            shiftOut <= 16'h0;
            bitsLeft <= 5'h0;
            cmdDone <= 1'b0;
        end else begin
            cmdDone <= 1'b0;
            if (hold != 32'h0)
                hold <= hold - 32'h1;
            case (hs)
                HS_WAIT: if (sinceUp >= 32'(VCSL_CYC)) hs <= HS_IDLE;
                HS_IDLE: begin
                    if (cmdValid && cmdReady) begin
                        shiftOut <= {cmdOpcode, RESET_CONFIRM};
                        bitsLeft <= cmdOpcode == OP_RESET ? 5'd16 : 5'd8;
                        hold <= 32'(HOST_CSLU_CYC);
                        hs <= HS_SEL;
                    end
                end
                HS_SEL: if (hold == 32'h0) hs <= HS_SHIFT;
                HS_SHIFT: begin
                    if (divCnt == 8'(HOST_DIV - 1) && sclk) begin
                        shiftOut <= {shiftOut[14:0], 1'b0};
                        bitsLeft <= bitsLeft - 5'h1;
                        if (bitsLeft == 5'h1)
                            hs <= HS_DESEL;
                    end
                end
                HS_DESEL: begin
                    hs <= HS_IDLE;
                    cmdDone <= 1'b1;
                    // Ultra-deep exit happens on next select; host backs off only after a 16-bit reset frame, whose upper byte shifts out to zero
                    if (shiftOut[15:8] == 8'h00 && bitsLeft == 5'h0)
                        hold <= 32'(XUDPD_CYC);
                end
                default: hs <= HS_WAIT;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link.chipSelectN <= 1'b1;
            link.serialClk <= 1'b0;
            link.mosi <= 1'b0;
        end else begin
            link.chipSelectN <= !(hs == HS_SEL || hs == HS_SHIFT);
            link.serialClk <= sclk;
            link.mosi <= shiftOut[15];
        end
    end
    // Ready already reflects the write startup wait, so a held write stays visible
    assign cmdReady = hs == HS_IDLE && hold == 32'h0 && (!isWrite(cmdOpcode) || sinceUp >= 32'(PUW_CYC));
endmodule
`default_nettype wire

// ---- sim/sfp_link_checker.sv ----
// Concurrent checks on the flash link between host and device
`timescale 1ns/1ns
`default_nettype none
module sfp_link_checker
    import sfp_pkg::*;
#(
    parameter int VCSL_CYC = HOST_VCSL_CYC,
    parameter int PUW_CYC = DEV_PUW_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic linkClk,
    input wire logic porRst,
    input wire logic chipSelectN,
    input wire logic serialClk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic misoOe,
    input wire logic [3:0] powerState,
    input wire logic clkMode3,
    input wire logic busy
);
    localparam int PUW_LIM = PUW_CYC + 4;
    localparam int EDPD_LIM = DEV_EDPD_CYC;
    localparam int RDPD_LIM = DEV_RDPD_CYC;
    logic [15:0] sinceRst;
    logic [7:0] edgeCnt;
    // Saturates so a long run never wraps back under the read delay
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sinceRst <= 16'h0000;
        end else if (sinceRst != 16'hFFFF) begin
            sinceRst <= sinceRst + 16'h0001;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst || chipSelectN) begin
            edgeCnt <= 8'h00;
        end else if ($rose(serialClk)) begin
            edgeCnt <= edgeCnt + 8'h01;
        end
    end
    a_oe_off_reset: assert property (@(posedge linkClk) porRst |=> !misoOe) else $error("data out driven in reset");
    a_oe_off_idle: assert property (@(posedge linkClk) disable iff (porRst)
        chipSelectN && $past(chipSelectN) |-> !misoOe) else $error("data out driven while deselected");
    a_mode_pick: assert property (@(posedge linkClk) disable iff (porRst)
        $fell(chipSelectN) && !serialClk |-> ##[1:3] !clkMode3) else $error("clock mode not taken from idle");
    a_por_quiet: assert property (@(posedge linkClk) porRst |=> powerState == 4'(PS_POR) && !busy)
        else $error("device active in power-on reset");
    a_startup_hold: assert property (@(posedge linkClk) disable iff (porRst)
        $fell(porRst) |-> (powerState <= 4'(PS_STARTUP) && !busy)[*8]) else $error("startup left early");
    a_startup_ends: assert property (@(posedge linkClk) disable iff (porRst)
        $fell(porRst) |-> ##[1:PUW_LIM] powerState > 4'(PS_STARTUP)) else $error("startup never ends");
    a_state_pick: assert property (@(posedge linkClk) disable iff (porRst)
        $past(powerState) == 4'(PS_STARTUP) && powerState != 4'(PS_STARTUP)
        |-> powerState == ($past(chipSelectN) ? 4'(PS_STANDBY) : 4'(PS_ACTIVE))) else $error("wrong state after startup");
    a_dpd_entry: assert property (@(posedge linkClk) disable iff (porRst)
        $rose(powerState == 4'(PS_ENTER_DPD)) |-> ##[0:EDPD_LIM] powerState == 4'(PS_DPD)) else $error("deep sleep late");
    a_udpd_entry: assert property (@(posedge linkClk) disable iff (porRst)
        $rose(powerState == 4'(PS_ENTER_UDPD)) |-> ##[0:EDPD_LIM] powerState == 4'(PS_UDPD)) else $error("ultra sleep late");
    a_resume_time: assert property (@(posedge linkClk) disable iff (porRst)
        $rose(powerState == 4'(PS_RESUME)) |-> ##[0:RDPD_LIM] powerState == 4'(PS_STANDBY)) else $error("resume late");
    a_clk_ceiling: assert property (@(posedge ref_clk) disable iff (srst)
        $changed(serialClk) |=> $stable(serialClk)) else $error("serial clock too fast");
    a_read_delay: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(chipSelectN) |-> sinceRst >= 16'(VCSL_CYC)) else $error("frame before read delay");
    a_whole_bytes: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(chipSelectN) |-> edgeCnt[2:0] == 3'h0 && edgeCnt != 8'h00) else $error("frame not whole bytes");
    c_busy: cover property (@(posedge linkClk) $fell(busy));
    c_dpd: cover property (@(posedge linkClk) powerState == 4'(PS_DPD));
    c_udpd_exit: cover property (@(posedge linkClk) powerState == 4'(PS_EXIT_UDPD));
endmodule
`default_nettype wire

// ---- sim/serial_flash_power_timing_test.sv ----
// Self-checking bench: host and flash device joined by one link
`timescale 1ns/1ns
`default_nettype none
module serial_flash_power_timing_test
    import sfp_pkg::*;
;
    localparam int D_PUW = 20;
    localparam int D_XU = 20;
    localparam int H_VCSL = 40;
    localparam int H_PUW = 200;
    logic ref_clk = 1'b0;
    logic linkClk = 1'b0;
    logic srst = 1'b1;
    logic porRst = 1'b1;
    logic cmdValid = 1'b0;
    logic [7:0] cmdOpcode = 8'h00;
    logic cmdReady, cmdDone, clkMode3, busy;
    logic [3:0] powerState;
    logic [7:0] lastOpcode;
    int fail_count = 0;
    int checks_done = 0;
    int busyCycles = 0;
    logic [7:0] wrOps [5] = '{OP_PAGE_PROG, OP_BLK64_ERASE, OP_CHIP_ERASE, OP_OTP_PROG, OP_WRITE_STATUS};
    int wrLim [5] = '{30, 40, 50, 25, DEV_WRSR_CYC};
    logic [7:0] rdOps [3] = '{OP_READ_SLOW, OP_READ_FAST, OP_READ_DUAL};
    sfp_link_if link ();
    always #10 ref_clk = ~ref_clk;
    // Odd offset keeps link edges off the host clock edges
    always begin
        if ($time == 0) #7;
        #80 linkClk = ~linkClk;
    end
    always @(posedge linkClk) if (busy === 1'b1) busyCycles++;
    sfp_flash_dev #(.PUW_CYC(D_PUW), .PP_CYC(30), .BLKE_CYC(40), .CHPE_CYC(50), .OTPP_CYC(25), .XUDPD_CYC(D_XU))
        sfp_flash_dev_i (.linkClk(linkClk), .porRst(porRst), .link(link.dev), .powerState(powerState),
        .clkMode3(clkMode3), .busy(busy), .lastOpcode(lastOpcode));
    sfp_flash_host #(.VCSL_CYC(H_VCSL), .PUW_CYC(H_PUW), .XUDPD_CYC(200)) sfp_flash_host_i (.ref_clk(ref_clk),
        .srst(srst), .link(link.host), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdReady(cmdReady),
        .cmdDone(cmdDone));
    sfp_link_checker #(.VCSL_CYC(H_VCSL), .PUW_CYC(D_PUW)) sfp_link_checker_i (.ref_clk(ref_clk), .srst(srst),
        .linkClk(linkClk), .porRst(porRst), .chipSelectN(link.chipSelectN), .serialClk(link.serialClk),
        .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe), .powerState(powerState),
        .clkMode3(clkMode3), .busy(busy));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] op);
        int n;
        n = 0;
        @(posedge ref_clk);
        cmdOpcode <= op;
        cmdValid <= 1'b1;
        @(negedge ref_clk);
        while (cmdReady !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        while (cmdDone !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        // Device sees the chip-select rise only after its synchroniser
        repeat (6) @(negedge linkClk);
        chk({7'h00, n < 20000}, 8'h01, "command completion");
    endtask
    task automatic wait_state(input logic [3:0] exp, input int lim);
        for (int n = 0; n < lim && powerState !== exp; n++) @(negedge linkClk);
        chk({4'h0, powerState}, {4'h0, exp}, "power state");
    endtask
    task automatic test_startup();
        repeat (2) @(negedge linkClk);
        chk({7'h00, link.misoOe}, 8'h00, "output enable after reset");
        chk({4'h0, powerState}, 8'(PS_STARTUP), "startup state");
        @(posedge ref_clk);
        cmdOpcode <= OP_PAGE_PROG;
        repeat (H_VCSL + 10) @(negedge ref_clk);
        chk({7'h00, cmdReady}, 8'h00, "write held off in startup");
        wait_state(4'(PS_STANDBY), D_PUW + 6);
    endtask
    task automatic test_reads();
        for (int i = 0; i < 3; i++) begin
            send(rdOps[i]);
            chk(lastOpcode, rdOps[i], "read opcode taken");
            chk({7'h00, clkMode3}, 8'h00, "clock mode");
        end
    endtask
    task automatic test_writes();
        for (int i = 0; i < 5; i++) begin
            busyCycles = 0;
            send(wrOps[i]);
            wait_state(4'(PS_STANDBY), wrLim[i] + 8);
            chk(lastOpcode, wrOps[i], "write opcode taken");
            // Short status write may finish inside the frame tail
            chk({7'h00, busyCycles <= wrLim[i] && (i == 4 || busyCycles > 0)}, 8'h01, "busy span");
        end
    endtask
    task automatic test_power();
        send(OP_DEEP_PD);
        wait_state(4'(PS_DPD), DEV_EDPD_CYC + 4);
        send(OP_READ_FAST);
        chk(lastOpcode, OP_DEEP_PD, "frame ignored in deep sleep");
        send(OP_RESUME);
        wait_state(4'(PS_STANDBY), DEV_RDPD_CYC + 4);
        send(OP_ULTRA_PD);
        wait_state(4'(PS_UDPD), DEV_EDPD_CYC + 4);
        send(8'h00);
        wait_state(4'(PS_STANDBY), D_XU + 8);
        send(OP_READ_FAST);
        chk(lastOpcode, OP_READ_FAST, "read after wake");
    endtask
    task automatic test_soft_reset();
        send(OP_RESET);
        chk(lastOpcode, OP_RESET, "reset opcode taken");
        wait_state(4'(PS_STANDBY), 40);
    endtask
    task automatic test_por_again();
        @(posedge linkClk);
        porRst <= 1'b1;
        repeat (3) @(negedge linkClk);
        chk({4'h0, powerState}, 8'(PS_POR), "held in power-on reset");
        chk({7'h00, link.misoOe}, 8'h00, "output off in reset");
        @(posedge linkClk);
        porRst <= 1'b0;
        wait_state(4'(PS_STANDBY), D_PUW + 8);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge linkClk);
        porRst <= 1'b0;
        @(posedge ref_clk);
        srst <= 1'b0;
        test_startup();
        test_reads();
        test_writes();
        test_power();
        test_soft_reset();
        test_por_again();
        print_verdict();
    end
    initial begin
        #1000000;
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
